/* File: verilog/pfer_pkg.sv */
// Summary of operation
// (RL1) 3-bit energy window length field, resets to 2, sets accumulator window.
// (RL2) energy present flag when accumulator exceeds detect threshold, resets to 2.
// (RL3) energy absent flag when accumulator below loss threshold, resets to 1.
// (RL4) port mirroring enable bit 0, resets to 0, 1 enables.
// (RL5) rx fifo threshold: two low bits here reset 2, top bit adjacent register.
// (RL6) receive path defaults to recovered-clock mode after reset.
// (RL7) software may lower rx threshold from 2 to 1 to cut latency.
// (RL8) tx fifo threshold: two low bits here reset 2, top bit adjacent bit 2.
// (RL9) tx skew select 0 skews tx clock, 1 aligns; resets to 0.
// (RL10) rx skew select 0 skews rx clock, 1 aligns; resets to 0.
// (RL11) software keeps unused bit 7 of rgmii control at 1 on writes.
// (RL12) energy-lost criterion applies only when criteria select bit 0 set.
// (RL13) reserved bits read zero and ignore writes.
package pfer_pkg;
	// register word addresses (index) of the printed map
	localparam logic [7:0] PFER_IDX_THR = 8'h2E;
	localparam logic [7:0] PFER_IDX_CRIT = 8'h2D;
	localparam logic [7:0] PFER_IDX_MIR = 8'h31;
	localparam logic [7:0] PFER_IDX_RGM = 8'h32;
	localparam logic [7:0] PFER_IDX_RGM2 = 8'h33;
	localparam logic [7:0] PFER_IDX_ACC = 8'h40;
	localparam logic [7:0] PFER_IDX_ISTS = 8'h41;
	localparam logic [7:0] PFER_IDX_ICLR = 8'h42;
	localparam logic [7:0] PFER_IDX_IEN = 8'h44;
	// field positions
	localparam int PFER_WIN_LSB = 8;
	localparam int PFER_DET_LSB = 4;
	localparam int PFER_LOSS_LSB = 0;
	localparam int PFER_RXT_LSB = 5;
	localparam int PFER_TXT_LSB = 3;
	localparam int PFER_RGM2_RXT_BIT = 0;
	localparam int PFER_RGM2_TXT_BIT = 2;
	// reset values and writable masks
	localparam logic [15:0] PFER_THR_RST = 16'h0221;
	localparam logic [15:0] PFER_THR_MASK = 16'h0777;
	localparam logic [15:0] PFER_CRIT_RST = 16'h0000;
	localparam logic [15:0] PFER_CRIT_MASK = 16'h001F;
	localparam logic [15:0] PFER_MIR_RST = 16'h0000;
	localparam logic [15:0] PFER_MIR_MASK = 16'h0001;
	localparam logic [15:0] PFER_RGM_RST = 16'h00D0;
	localparam logic [15:0] PFER_RGM_MASK = 16'h00FF;
	localparam logic [15:0] PFER_RGM2_RST = 16'h0000;
	localparam logic [15:0] PFER_RGM2_MASK = 16'h001F;
	localparam logic [3:0] PFER_IRQ_MASK = 4'hF;
	// interrupt bit positions
	localparam int PFER_IRQ_PRESENT = 0;
	localparam int PFER_IRQ_ABSENT = 1;
	localparam int PFER_IRQ_DROP = 2;
	localparam int PFER_IRQ_LINKCLK = 3;
endpackage : pfer_pkg

/* File: verilog/pfer_energy_acc.sv */
`timescale 1ns/10ps
// energy accumulator: counts sampled energy over a window of 2^(len+1) link clock edges
module pfer_energy_acc
	import pfer_pkg::*;
(
	// clock and reset
	input wire logic I_SYS_CLK,
	input wire logic I_SYS_RST,
	// control
	input wire logic i_edge,
	input wire logic i_energy,
	input wire logic [2:0] i_window_len,
	// result
	output logic o_done,
	output logic [2:0] o_value
);
	typedef struct packed {
		logic [8:0] win_cnt;
		logic [8:0] acc;
		logic done;
		logic [2:0] value;
	} pfer_acc_t;
	pfer_acc_t st;
	pfer_acc_t next_st;
	logic [8:0] win_last;
	logic [11:0] scaled;

	// window end and scaled result; value is the fraction of the window in eighths
	// a full window scales to eight, which three bits cannot hold, so it saturates
	always_comb begin
		win_last = 9'((9'h002 << i_window_len) - 9'h001); // RL1
		scaled = ((st.acc + 9'(i_energy)) * 12'h008) >> (4'(i_window_len) + 4'h1); // RL1
		next_st = st;
		next_st.done = 1'b0;
		if (i_edge) begin
			if (st.win_cnt >= win_last) begin
				next_st.win_cnt = 9'h000;
				next_st.acc = 9'h000;
				next_st.done = 1'b1;
				next_st.value = (scaled > 12'h007) ? 3'h7 : scaled[2:0]; // RL1
			end else begin
				next_st.win_cnt = st.win_cnt + 9'h001;
				next_st.acc = st.acc + 9'(i_energy);
			end
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) st <= '0;
		else st <= next_st;
	end

	assign o_done = st.done;
	assign o_value = st.value;
endmodule : pfer_energy_acc

/* File: verilog/pfer_top.sv */
`timescale 1ns/10ps
module pfer_top
	import pfer_pkg::*;
(
	// clock and reset
	input wire logic I_SYS_CLK,
	input wire logic I_SYS_RST,
	// apb slave
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [11:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	// link side inputs
	input wire logic I_LINK_CLK,
	input wire logic I_ENERGY,
	// status and controls to the datapath
	output logic O_ENERGY_PRESENT,
	output logic O_ENERGY_ABSENT,
	output logic O_FAST_LINK_DROP,
	output logic O_PORT_MIRROR_EN,
	output logic [2:0] O_RX_FIFO_FILL_THRESHOLD,
	output logic [2:0] O_TX_FIFO_FILL_THRESHOLD,
	output logic O_TX_CLK_SKEW,
	output logic O_RX_CLK_SKEW,
	output logic O_RX_RECOVERED_MODE,
	output logic O_IRQ
);
	typedef struct packed {
		logic [1:0] lclk_sync;
		logic [1:0] en_sync;
		logic lclk_prev;
		logic [15:0] thr;
		logic [15:0] crit;
		logic [15:0] mir;
		logic [15:0] rgm;
		logic [15:0] rgm2;
		logic [3:0] ists;
		logic [3:0] ien;
		logic present;
		logic absent;
		logic drop;
		logic [2:0] acc_val;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
		logic tx_skew;
		logic rx_skew;
		logic rx_recov;
	} pfer_top_t;
	pfer_top_t st;
	pfer_top_t next_st;

	logic link_edge;
	logic acc_done;
	logic [2:0] acc_value;
	logic [9:0] word_idx;
	logic access;
	logic commit;
	logic mapped;
	logic [15:0] rd_word;
	logic [3:0] events;
	logic [2:0] win_len;

	// link clock is an outside pin: the second flop and its delayed copy feed the edge finder
	assign link_edge = st.lclk_sync[1] & ~st.lclk_prev;
	assign win_len = st.thr[PFER_WIN_LSB +: 3];

	pfer_energy_acc u_acc (
		.I_SYS_CLK(I_SYS_CLK),
		.I_SYS_RST(I_SYS_RST),
		.i_edge(link_edge),
		.i_energy(st.en_sync[1]),
		.i_window_len(win_len),
		.o_done(acc_done),
		.o_value(acc_value)
	);

	// byte address to word index; all ten upper address bits are decoded, so nothing aliases
	assign word_idx = I_PADDR[11:2];
	assign access = I_PSEL & I_PENABLE & ~st.pready;
	// completing edge: ready already high and the request still held
	assign commit = I_PSEL & I_PENABLE & st.pready;
	assign mapped = (I_PADDR[1:0] == 2'h0) &&
		(word_idx == 10'(PFER_IDX_THR) || word_idx == 10'(PFER_IDX_CRIT) ||
		word_idx == 10'(PFER_IDX_MIR) || word_idx == 10'(PFER_IDX_RGM) ||
		word_idx == 10'(PFER_IDX_RGM2) || word_idx == 10'(PFER_IDX_ACC) ||
		word_idx == 10'(PFER_IDX_ISTS) || word_idx == 10'(PFER_IDX_ICLR) ||
		word_idx == 10'(PFER_IDX_IEN));

	// read mux; reserved bits were never stored so they read zero
	always_comb begin
		rd_word = 16'h0000;
		if (word_idx == 10'(PFER_IDX_THR)) rd_word = st.thr;
		else if (word_idx == 10'(PFER_IDX_CRIT)) rd_word = st.crit;
		else if (word_idx == 10'(PFER_IDX_MIR)) rd_word = st.mir;
		else if (word_idx == 10'(PFER_IDX_RGM)) rd_word = st.rgm;
		else if (word_idx == 10'(PFER_IDX_RGM2)) rd_word = st.rgm2;
		else if (word_idx == 10'(PFER_IDX_ACC)) rd_word = {13'h0, st.acc_val};
		else if (word_idx == 10'(PFER_IDX_ISTS)) rd_word = {12'h000, st.ists};
		else if (word_idx == 10'(PFER_IDX_IEN)) rd_word = {12'h000, st.ien};
	end

	// event sources for the sticky status register
	assign events = {link_edge & ~st.lclk_prev,
		acc_done & (acc_value < st.thr[PFER_LOSS_LSB +: 3]) & st.crit[0],
		acc_done & (acc_value < st.thr[PFER_LOSS_LSB +: 3]) & ~st.absent,
		acc_done & (acc_value > st.thr[PFER_DET_LSB +: 3]) & ~st.present};

	always_comb begin
		next_st = st;
		next_st.lclk_sync = {st.lclk_sync[0], I_LINK_CLK};
		next_st.en_sync = {st.en_sync[0], I_ENERGY};
		next_st.lclk_prev = st.lclk_sync[1];
		// ready pulses one edge into the access phase; the write lands only at the
		// edge that sees ready, so an abandoned request never changes a register
		next_st.pready = access;
		next_st.pslverr = access & ~mapped;
		next_st.prdata = 32'h0000_0000;
		if (access && !I_PWRITE && mapped) next_st.prdata = {16'h0000, rd_word};
		// writes; masks keep reserved bits at zero
		if (commit && I_PWRITE && mapped) begin
			unique case (1'b1)
				word_idx == 10'(PFER_IDX_THR):
					next_st.thr = I_PWDATA[15:0] & PFER_THR_MASK; // RL13
				word_idx == 10'(PFER_IDX_CRIT):
					next_st.crit = I_PWDATA[15:0] & PFER_CRIT_MASK;
				word_idx == 10'(PFER_IDX_MIR):
					next_st.mir = I_PWDATA[15:0] & PFER_MIR_MASK; // RL4
				word_idx == 10'(PFER_IDX_RGM):
					next_st.rgm = I_PWDATA[15:0] & PFER_RGM_MASK; // RL11
				word_idx == 10'(PFER_IDX_RGM2):
					next_st.rgm2 = I_PWDATA[15:0] & PFER_RGM2_MASK;
				word_idx == 10'(PFER_IDX_IEN):
					next_st.ien = I_PWDATA[3:0] & PFER_IRQ_MASK;
				default: begin
				end
			endcase
		end
		// clear by write-one, then set; a same-cycle event wins
		if (commit && I_PWRITE && mapped && word_idx == 10'(PFER_IDX_ICLR))
			next_st.ists = st.ists & ~I_PWDATA[3:0];
		next_st.ists = next_st.ists | events;
		// energy verdict updates once per window
		if (acc_done) begin
			next_st.acc_val = acc_value;
			next_st.present = acc_value > st.thr[PFER_DET_LSB +: 3]; // RL2
			next_st.absent = acc_value < st.thr[PFER_LOSS_LSB +: 3]; // RL3
			next_st.drop = st.crit[0] & (acc_value < st.thr[PFER_LOSS_LSB +: 3]); // RL12
		end
		if (!st.crit[0]) next_st.drop = 1'b0; // RL12
		// skew and mode pins follow the next register image, so no cycle of lag
		next_st.tx_skew = ~next_st.rgm[1]; // RL9
		next_st.rx_skew = ~next_st.rgm[0]; // RL10
		next_st.rx_recov = ~next_st.rgm2[4]; // RL6
		next_st.irq = |(next_st.ists & next_st.ien);
	end

	// reset values of all stored state
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) begin
			st <= '0;
			st.thr <= PFER_THR_RST; // RL1
			st.crit <= PFER_CRIT_RST;
			st.mir <= PFER_MIR_RST; // RL4
			st.rgm <= PFER_RGM_RST; // RL5
			st.rgm2 <= PFER_RGM2_RST; // RL6
			st.tx_skew <= ~PFER_RGM_RST[1]; // RL9
			st.rx_skew <= ~PFER_RGM_RST[0]; // RL10
			st.rx_recov <= ~PFER_RGM2_RST[4]; // RL6
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from state flops
	assign O_PRDATA = st.prdata;
	assign O_PREADY = st.pready;
	assign O_PSLVERR = st.pslverr;
	assign O_ENERGY_PRESENT = st.present;
	assign O_ENERGY_ABSENT = st.absent;
	assign O_FAST_LINK_DROP = st.drop;
	assign O_PORT_MIRROR_EN = st.mir[0];
	assign O_RX_FIFO_FILL_THRESHOLD = {st.rgm2[PFER_RGM2_RXT_BIT], st.rgm[PFER_RXT_LSB +: 2]}; // RL5
	assign O_TX_FIFO_FILL_THRESHOLD = {st.rgm2[PFER_RGM2_TXT_BIT], st.rgm[PFER_TXT_LSB +: 2]}; // RL8
	assign O_TX_CLK_SKEW = st.tx_skew; // RL9
	assign O_RX_CLK_SKEW = st.rx_skew; // RL10
	// recovered mode is the reset default; its own selector lives elsewhere
	assign O_RX_RECOVERED_MODE = st.rx_recov; // RL6
	assign O_IRQ = st.irq;
endmodule : pfer_top

/* File: test/pfer_link_src.sv */
`timescale 1ns/10ps
// link side stand-in: detector level and a link clock that runs only in bursts
module pfer_link_src (
	// link pins
	output logic o_link_clk,
	output logic o_energy,
	// bench control
	input wire logic i_run,
	input wire logic i_energy_on
);
	// odd start offset keeps link edges clear of system clock edges
	initial begin
		o_link_clk = 1'b0;
		#137;
		forever #400 o_link_clk = i_run ? ~o_link_clk : 1'b0;
	end
	assign o_energy = i_energy_on;
endmodule : pfer_link_src

/* File: test/pfer_chk_sva.sv */
`timescale 1ns/10ps
module pfer_chk (
	// clock, reset and apb
	input wire logic I_SYS_CLK,
	input wire logic I_SYS_RST,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [11:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	input wire logic [31:0] O_PRDATA,
	input wire logic O_PREADY,
	input wire logic O_PSLVERR,
	// datapath controls
	input wire logic O_ENERGY_ABSENT,
	input wire logic O_FAST_LINK_DROP,
	input wire logic O_PORT_MIRROR_EN,
	input wire logic [2:0] O_RX_FIFO_FILL_THRESHOLD,
	input wire logic [2:0] O_TX_FIFO_FILL_THRESHOLD,
	input wire logic O_TX_CLK_SKEW,
	input wire logic O_RX_CLK_SKEW,
	input wire logic O_RX_RECOVERED_MODE
);
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (I_SYS_RST);
	// access phase still waiting for its answer
	wire acc = I_PSEL && I_PENABLE && !O_PREADY;
	// bus answer timing
	ready_pulse_a: assert property (O_PREADY |=> !O_PREADY) else $error("ready held");
	answer_time_a: assert property (acc |=> O_PREADY) else $error("late answer");
	ready_cause_a: assert property (O_PREADY |-> $past(acc)) else $error("stray ready");
	rdata_idle_a: assert property (!O_PREADY |-> O_PRDATA == 32'h0) else $error("stray data");
	upper_zero_a: assert property (O_PRDATA[31:16] == 16'h0) else $error("upper set");
	misalign_err_a: assert property (acc && I_PADDR[1:0] != 2'h0 |=> O_PSLVERR)
		else $error("misaligned accepted");
	// register effects at the pins
	mirror_write_a: assert property (O_PREADY && !O_PSLVERR && I_PWRITE
		&& I_PADDR == 12'h0C4 |=> O_PORT_MIRROR_EN == $past(I_PWDATA[0]))
		else $error("mirror not written");
	reset_vals_a: assert property ($fell(I_SYS_RST) |-> {O_RX_FIFO_FILL_THRESHOLD,
		O_TX_FIFO_FILL_THRESHOLD, O_TX_CLK_SKEW, O_RX_CLK_SKEW, O_RX_RECOVERED_MODE} == 9'h097)
		else $error("bad reset state");
	drop_absent_a: assert property (O_FAST_LINK_DROP |-> O_ENERGY_ABSENT) else $error("no loss");
	cover property (O_PSLVERR);
	cover property (O_FAST_LINK_DROP);
	cover property (O_PREADY && I_PWRITE);
endmodule : pfer_chk

/* File: test/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
	import pfer_pkg::*;
	// bench drive and observed pins
	logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, run = 1'b0, en = 1'b0;
	logic [11:0] addr = 12'h000;
	logic [31:0] wdata = 32'h0, rdata, rv;
	logic rdy, err, ev, lclk, energy, present, absent, drop, mirror, txsk, rxsk, recov, irq;
	logic [2:0] rxt, txt;
	int num_errors = 0;
	int total_checks = 0;
	logic [7:0] idx [5] = '{PFER_IDX_THR, PFER_IDX_CRIT, PFER_IDX_MIR, PFER_IDX_RGM, PFER_IDX_RGM2};
	always #50 clk = ~clk;
	pfer_link_src u_src (.o_link_clk(lclk), .o_energy(energy), .i_run(run), .i_energy_on(en));
	pfer_top dut (.I_SYS_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
		.I_PADDR(addr), .I_PWDATA(wdata), .O_PRDATA(rdata), .O_PREADY(rdy), .O_PSLVERR(err),
		.I_LINK_CLK(lclk), .I_ENERGY(energy), .O_ENERGY_PRESENT(present),
		.O_ENERGY_ABSENT(absent), .O_FAST_LINK_DROP(drop), .O_PORT_MIRROR_EN(mirror),
		.O_RX_FIFO_FILL_THRESHOLD(rxt), .O_TX_FIFO_FILL_THRESHOLD(txt), .O_TX_CLK_SKEW(txsk),
		.O_RX_CLK_SKEW(rxsk), .O_RX_RECOVERED_MODE(recov), .O_IRQ(irq));
	// packed views of the control and flag pins
	function automatic logic [31:0] cfg();
		return {22'h0, rxt, txt, txsk, rxsk, recov, mirror};
	endfunction : cfg
	function automatic logic [31:0] flg();
		return {28'h0, irq, drop, absent, present};
	endfunction : flg
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// sample away from the edge so register updates have landed
	task automatic wt(input int c);
		repeat (c) @(posedge clk);
		@(negedge clk);
	endtask : wt
	// one apb transfer; rv and ev hold the answer; only the watchdog ends a hang
	task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d, input logic [1:0] o);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		addr <= {2'h0, i, o};
		wdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
		end while (rdy !== 1'b1);
		rv = rdata;
		ev = err;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	task automatic t_reset;
		logic [15:0] exp [5] = '{16'h0221, 16'h0000, 16'h0000, 16'h00D0, 16'h0000};
		wt(0);
		chk(cfg(), 32'h12E);
		for (int k = 0; k < 5; k++) begin
			apb(1'b0, idx[k], 32'h0, 2'h0);
			chk(rv, {16'h0, exp[k]});
		end
	endtask : t_reset
	// all ones stick only in writable bits; bit 7 of the control kept at 1
	task automatic t_regs;
		logic [15:0] msk [5] = '{16'h0777, 16'h001F, 16'h0001, 16'h00FF, 16'h001F};
		for (int k = 0; k < 5; k++) begin
			apb(1'b1, idx[k], 32'hFFFFFFFF, 2'h0);
			apb(1'b0, idx[k], 32'h0, 2'h0);
			chk(rv, {16'h0, msk[k]});
		end
		wt(0);
		chk(cfg(), 32'h3F1);
		apb(1'b1, PFER_IDX_RGM2, 32'h0, 2'h0);
		apb(1'b1, PFER_IDX_RGM, 32'hB0, 2'h0);
		wt(0);
		chk(cfg(), 32'h0AF);
	endtask : t_regs
	// misaligned and unmapped accesses refused, nothing changes
	task automatic t_err;
		apb(1'b1, PFER_IDX_THR, 32'h0, 2'h1);
		chk({31'h0, ev}, 32'h1);
		apb(1'b0, 8'hFF, 32'h0, 2'h0);
		chk({31'h0, ev}, 32'h1);
		chk(rv, 32'h0);
		apb(1'b0, PFER_IDX_THR, 32'h0, 2'h0);
		chk(rv, 32'h0777);
	endtask : t_err
	// two-edge window: energy on, then off; interrupt masked, enabled, cleared
	task automatic t_energy;
		apb(1'b1, PFER_IDX_THR, 32'h0021, 2'h0);
		apb(1'b1, PFER_IDX_CRIT, 32'h1, 2'h0);
		apb(1'b1, PFER_IDX_IEN, 32'h0, 2'h0);
		run <= 1'b1;
		en <= 1'b1;
		wt(100);
		chk(flg(), 32'h1);
		apb(1'b0, PFER_IDX_ACC, 32'h0, 2'h0);
		chk(rv, 32'h7);
		en <= 1'b0;
		wt(100);
		chk(flg(), 32'h6);
		apb(1'b1, PFER_IDX_CRIT, 32'h0, 2'h0);
		run <= 1'b0;
		wt(10);
		chk(flg(), 32'h2);
		apb(1'b1, PFER_IDX_IEN, 32'hF, 2'h0);
		wt(3);
		chk(flg(), 32'hA);
		apb(1'b0, PFER_IDX_ISTS, 32'h0, 2'h0);
		chk(rv, 32'hF);
		apb(1'b1, PFER_IDX_ICLR, 32'hF, 2'h0);
		wt(3);
		chk(flg(), 32'h2);
	endtask : t_energy
	task automatic conclude;
		if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : conclude
	// hang guard: the sequence needs well under 100 us
	initial begin
		#1000000;
		num_errors++;
		conclude();
	end
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_regs();
		t_err();
		t_energy();
		conclude();
	end
endmodule : tb_top
bind pfer_top pfer_chk u_chk (.*);
